//--- logic/hbp_defines.svh
// holds widths, reset values and timing counts for the host bus port
// assumes nothing beyond a plain include by bare name
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH
// ************************************************************
// widths
// ************************************************************
`define HBP_DATA_W 8
`define HBP_ADDR_W 6
`define HBP_NUM_REGS 64
`define HBP_NUM_SRC 4
`define HBP_LEVEL_W 8
// ************************************************************
// reset values and timing
// ************************************************************
`define HBP_REG_RST 8'h00
`define HBP_THRESH_RST 8'h00
// ack delay count, not used by the port, which raises the acknowledge two cycles after taking the strobe
`define HBP_ACK_DELAY 2'h1
`endif

//--- logic/hbp_pkg.sv
// types shared by the host bus port
// assumes hbp_defines.svh is on the include path
`include "hbp_defines.svh"
package hbp_pkg;
  // access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_ACK
  } hbp_state_t;
  // host strobes and select
  typedef struct packed {
    logic chip_enable_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [`HBP_ADDR_W-1:0] register_select;
  } hbp_host_ctl_t;
  // tri-state bundle of one pin group
  typedef struct packed {
    logic [`HBP_DATA_W-1:0] dout;
    logic [`HBP_DATA_W-1:0] doe_n;
  } hbp_data_pin_t;
endpackage : hbp_pkg

//--- logic/hbp_port.sv
// host bus strobe and acknowledge port with register store and irq level check
// assumes host strobes synchronous to i_core_clk; the board resolves open-drain wires
// How it works
// - write strobe with enable stores data byte
// - acknowledge pulled low after each access completes
// - read acknowledge only once data is driven
// - write acknowledge only after byte latched
// - irq low when enabled source exceeds threshold
// - read strobe with enable drives selected register
`timescale 1ns/1ps
`include "hbp_defines.svh"
module hbp_port #(
  parameter int NUM_SRC = `HBP_NUM_SRC,
  parameter int LEVEL_W = `HBP_LEVEL_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_chip_enable_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic [`HBP_ADDR_W-1:0] i_register_select,
  input wire logic [`HBP_DATA_W-1:0] i_host_data_bus,
  input wire logic [NUM_SRC*LEVEL_W-1:0] i_src_level,
  input wire logic [NUM_SRC-1:0] i_src_enable,
  input wire logic [LEVEL_W-1:0] i_irq_threshold,
  output logic [`HBP_DATA_W-1:0] o_host_data_bus,
  output logic [`HBP_DATA_W-1:0] o_host_data_oe_n,
  output logic o_access_ack_n,
  output logic o_access_ack_oe_n,
  output logic o_int_request_n,
  output logic o_int_request_oe_n
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // a zero count or width would leave the irq compare with nothing to do
  if (NUM_SRC < 1 || LEVEL_W < 1) begin : g_bad_param
    $error("hbp_port: source count and level width must be positive");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    hbp_pkg::hbp_state_t st;
    logic is_read;                              // access kind latched at start
    logic [`HBP_ADDR_W-1:0] sel;                // latched register select
    logic [`HBP_DATA_W-1:0] rdata;              // read data on the bus
    logic [`HBP_DATA_W-1:0] doe_n;              // data enable, low drives
    logic ack_oe_n;                             // ack enable, low pulls
    logic irq_oe_n;                             // irq enable, low pulls
  } hbp_port_state_t;

  hbp_port_state_t state_ff;
  hbp_port_state_t nxt_state;
  logic [`HBP_DATA_W-1:0] regs_ff [`HBP_NUM_REGS];  // register store
  logic wr_en;                                       // one-cycle store strobe
  logic [NUM_SRC-1:0] over;                          // per source above level
  hbp_pkg::hbp_host_ctl_t ctl;                       // bundled host controls

  assign ctl = '{chip_enable_n: i_chip_enable_n, read_strobe_n: i_read_strobe_n,
                 write_strobe_n: i_write_strobe_n, register_select: i_register_select};

  // ************************************************************
  // interrupt level compare
  // ************************************************************
  // compare runs every cycle, independent of host accesses
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    // enabled source strictly above programmed level
    assign over[g] = i_src_enable[g] &&
                     (i_src_level[g*LEVEL_W +: LEVEL_W] > i_irq_threshold);
  end

  // ************************************************************
  // access sequencer
  // ************************************************************
  // strobe active while enable also low
  logic rd_req;
  logic wr_req;
  assign rd_req = !ctl.chip_enable_n && !ctl.read_strobe_n;
  assign wr_req = !ctl.chip_enable_n && !ctl.write_strobe_n;

  // next state of the whole port
  // read wins when both strobes fall together
  // write data is taken one edge after the strobe, so the host must hold it
  // an access cut in settle leaves the store and the ack untouched
  always_comb begin
    nxt_state = state_ff;
    wr_en = 1'b0;
    nxt_state.irq_oe_n = ~(|over);
    case (state_ff.st)
      hbp_pkg::ST_IDLE: begin
        if (rd_req || wr_req) begin
          nxt_state.st = hbp_pkg::ST_SETTLE;
          nxt_state.is_read = rd_req;
          nxt_state.sel = ctl.register_select;
        end
      end
      hbp_pkg::ST_SETTLE: begin
        if (!(rd_req || wr_req)) begin
          nxt_state.st = hbp_pkg::ST_IDLE;          // aborted access
        end else if (state_ff.is_read) begin
          // drive data first, ack follows a cycle later
          nxt_state.rdata = regs_ff[state_ff.sel];
          nxt_state.doe_n = '0;
          nxt_state.st = hbp_pkg::ST_ACK;
        end else begin
          wr_en = 1'b1;
          nxt_state.st = hbp_pkg::ST_ACK;
        end
      end
      hbp_pkg::ST_ACK: begin
        // hold ack until the host lets go of the strobe or enable
        if (rd_req || wr_req) begin
          nxt_state.ack_oe_n = 1'b0;
        end else begin
          nxt_state.ack_oe_n = 1'b1;
          nxt_state.doe_n = '1;
          nxt_state.st = hbp_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state.st = hbp_pkg::ST_IDLE;
      end
    endcase
  end

  // register the port state
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_ff <= '{st: hbp_pkg::ST_IDLE, is_read: 1'b0, sel: '0, rdata: '0,
                    doe_n: '1, ack_oe_n: 1'b1, irq_oe_n: 1'b1};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // register store, written on the latched select
  // the select is latched at the take edge, so an address that moves
  // during the access cannot retarget the store
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < `HBP_NUM_REGS; k++) begin
        regs_ff[k] <= `HBP_REG_RST;
      end
    end else if (wr_en) begin
      regs_ff[state_ff.sel] <= i_host_data_bus;
    end
  end

  // ************************************************************
  // outputs: data and enables straight from flip-flops, ack and irq pin levels tied low
  // ************************************************************
  // ack and irq pins only ever pull low; their enables carry the level
  // the board pull-ups give the released high
  assign o_host_data_bus = state_ff.rdata;
  assign o_host_data_oe_n = state_ff.doe_n;
  assign o_access_ack_n = 1'b0;                     // open drain, only pulls low
  assign o_access_ack_oe_n = state_ff.ack_oe_n;
  assign o_int_request_n = 1'b0;
  assign o_int_request_oe_n = state_ff.irq_oe_n;

  // ************************************************************
  // checks
  // ************************************************************
  // read ack only while data is driven
  chk_read_ack_data: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!state_ff.ack_oe_n && state_ff.is_read) |-> (state_ff.doe_n == '0))
    else $error("read ack without driven data");

  sequence s_write_start;
    $rose(wr_req) && state_ff.st == hbp_pkg::ST_IDLE && !rd_req;
  endsequence
  sequence s_held3;
    wr_req [*3];
  endsequence
  // held write shows ack the edge after three held cycles
  chk_write_ack_time: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_write_start ##0 s_held3 |=> !state_ff.ack_oe_n)
    else $error("write ack late");
  chk_write_stored: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wr_en |=> regs_ff[$past(state_ff.sel)] == $past(i_host_data_bus))
    else $error("write byte not stored");
  chk_ack_after_store: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($fell(state_ff.ack_oe_n) && !state_ff.is_read) |-> $past(wr_en, 2))
    else $error("write ack before latch");
  chk_read_data_value: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(state_ff.doe_n[0]) |-> state_ff.rdata == regs_ff[state_ff.sel])
    else $error("wrong read data");
  chk_release_ack: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!state_ff.ack_oe_n && !(rd_req || wr_req)) |=>
      (state_ff.ack_oe_n && &state_ff.doe_n))
    else $error("ack or bus not released");
  chk_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (|over) |=> !state_ff.irq_oe_n)
    else $error("irq not raised");
  chk_irq_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !(|over) |=> state_ff.irq_oe_n)
    else $error("irq without source");

  // ************************************************************
  // access hold and release checks
  // ************************************************************
  // an idle port drives neither ack nor bus
  chk_idle_released: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_ff.st == hbp_pkg::ST_IDLE) |-> (state_ff.ack_oe_n && &state_ff.doe_n))
    else $error("idle port still driving");
  // ack stands while the host keeps the strobe
  chk_ack_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!state_ff.ack_oe_n && (rd_req || wr_req)) |=> !state_ff.ack_oe_n)
    else $error("ack dropped early");
  sequence s_cut_settle;
    state_ff.st == hbp_pkg::ST_SETTLE && !(rd_req || wr_req);
  endsequence
  // a strobe lifted in settle ends the access with no ack
  chk_abort_no_ack: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_cut_settle |=> (state_ff.st == hbp_pkg::ST_IDLE && state_ff.ack_oe_n))
    else $error("cut access not ended");
  // read data stands unchanged while acknowledged
  chk_read_data_stable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!state_ff.ack_oe_n && state_ff.is_read) |=> $stable(state_ff.rdata))
    else $error("read data moved under ack");

endmodule // hbp_port

//--- bench/hbp_host_model.sv
// host bus master model: strobes, select and write data
// assumes the bench resolves the open-drain ack and the data bus
`timescale 1ns/1ps
module hbp_host_model (
  input wire logic i_core_clk,
  input wire logic i_ack_n,
  input wire logic [7:0] i_bus,
  output hbp_pkg::hbp_host_ctl_t o_ctl,
  output logic [7:0] o_data
);
  // ************************************************************
  // bus cycle
  // ************************************************************
  initial begin
    o_ctl = '1;
    o_data = 8'h5a;
  end
  // one access; cut lifts strobes early, cyc counts edges to ack
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
                      input int cut, output logic [7:0] q, output int cyc);
    @(posedge i_core_clk);
    o_ctl <= '{1'b0, !rd, rd, a};
    o_data <= rd ? ~o_data : d;
    cyc = 0;
    do begin
      @(posedge i_core_clk);
      cyc++;
    end while (i_ack_n !== 1'b0 && cyc != cut && cyc < 20);
    q = i_bus;
    o_ctl <= '1;
    o_data <= ~o_data;  // released bus shows no stale value
    @(posedge i_core_clk);
  endtask
endmodule // hbp_host_model

//--- bench/hbp_port_test.sv
// self-checking bench for the host bus port
// assumes design files and host model are compiled first
`timescale 1ns/1ps
module hbp_port_test;
  // ************************************************************
  // clock, wires, bookkeeping
  // ************************************************************
  logic i_core_clk = 0;
  logic i_rst_n = 0;
  logic [31:0] rs = 32'h21, lvl = 0;
  logic [3:0] en = 0;
  logic [7:0] thr = 0, dq, dv, hd, d_o, d_oe_n, bus, mem [64];
  logic ack_n, ack_oe_n, irq_n, irq_oe_n, ack_w, ack_q = 1, irq_x = 1;
  hbp_pkg::hbp_host_ctl_t ctl;
  logic [7:0] exp_q [$];
  int num_errors = 0, check_count = 0, cyc, ticks = 0;
  always #20 i_core_clk = ~i_core_clk;
  assign ack_w = ack_oe_n ? 1'b1 : ack_n;  // pull-up when released
  assign bus = &d_oe_n ? hd : d_o;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic hit(input logic [31:0] l, input logic [3:0] e,
                               input logic [7:0] t);
    hit = 1'b0;
    for (int g = 0; g < 4; g++) hit |= e[g] && (l[g*8+:8] > t);
  endfunction
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  hbp_port dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_chip_enable_n(ctl.chip_enable_n), .i_read_strobe_n(ctl.read_strobe_n),
    .i_write_strobe_n(ctl.write_strobe_n), .i_register_select(ctl.register_select),
    .i_host_data_bus(bus), .i_src_level(lvl), .i_src_enable(en),
    .i_irq_threshold(thr), .o_host_data_bus(d_o), .o_host_data_oe_n(d_oe_n),
    .o_access_ack_n(ack_n), .o_access_ack_oe_n(ack_oe_n),
    .o_int_request_n(irq_n), .o_int_request_oe_n(irq_oe_n));
  hbp_host_model u_host (.i_core_clk(i_core_clk), .i_ack_n(ack_w), .i_bus(bus),
    .o_ctl(ctl), .o_data(hd));
  // random irq inputs, watcher of read data and irq, timeout
  always @(posedge i_core_clk) begin
    ticks++;
    rs <= xs(rs);
    lvl <= xs(rs);
    en <= rs[3:0];
    thr <= rs[15:8];
    if (ticks > 1) chk((irq_oe_n ? 1'b1 : irq_n) === irq_x, "irq level");
    irq_x <= !(i_rst_n && hit(lvl, en, thr));
    if (ack_q && !ack_w && !ctl.read_strobe_n) begin
      dv = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      chk(bus === dv && d_oe_n === 8'h00, "read data");
    end
    ack_q <= ack_w;
    if (ticks > 4000) begin
      num_errors++;
      test_done;
    end
  end
  // one access with its release and timing checks
  task automatic acc(input logic rd, input logic [5:0] a, input logic [7:0] d,
                     input int cut);
    if (rd && cut == 0) exp_q.push_back(mem[a]);
    u_host.xfer(rd, a, d, cut, dq, cyc);
    #1;
    chk(ack_w === 1'b1 && d_oe_n === 8'hff, "release");
    if (rd && cut == 0) chk(dq === mem[a], "host read");
    if (cut == 0) chk(cyc inside {[4:5]}, "ack timing");
    if (!rd && cut == 0) mem[a] = d;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 64; i += 9) acc(1'b1, 6'(i), 8'h00, 0);
    for (int i = 0; i < 64; i++) acc(1'b0, 6'(i), rs[7:0] ^ 8'(i), 0);
    for (int i = 63; i >= 0; i--) acc(1'b1, 6'(i), 8'h00, 0);
    acc(1'b0, 6'h05, ~mem[5], 1);  // aborted write leaves old byte
    acc(1'b1, 6'h05, 8'h00, 0);
    acc(1'b1, 6'h07, 8'h00, 1);  // aborted read gives no ack
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    acc(1'b1, 6'h3f, 8'h00, 0);
    acc(1'b1, 6'h00, 8'h00, 0);
    test_done;
  end
endmodule // hbp_port_test
